// File: psc_pkg.sv
// shared constants, pin indices and carrier types for the passive serial configuration slave
// assumes a 40 MHz reference clock and a separate serial configuration clock from the host
package psc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS     = 25;
  localparam int POR_NS            = 5000;
  localparam int STATUS_MIN_NS     = 1000;
  localparam int STATUS_REL_MAX_NS = 4000;
  localparam int REQ_FALL_MAX_NS   = 200;
  localparam int STARTUP_MIN_NS    = 600;
  localparam int STARTUP_MAX_NS    = 2000;

  localparam logic [7:0] POR_CYC        = 8'((POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STATUS_MIN_CYC = 8'((STATUS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STATUS_REL_CYC = 8'(STATUS_REL_MAX_NS / CLK_PERIOD_NS);
  localparam logic [7:0] REQ_FALL_CYC   = 8'(REQ_FALL_MAX_NS / CLK_PERIOD_NS);
  localparam logic [7:0] STARTUP_LO_CYC = 8'((STARTUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STARTUP_HI_CYC = 8'(STARTUP_MAX_NS / CLK_PERIOD_NS);
  localparam logic [7:0] STARTUP_CYC    = 8'((STARTUP_LO_CYC + STARTUP_HI_CYC) / 2);
  localparam logic [7:0] USER_STARTUP_EDGES = 8'h0a;

  ////////////////////////////////////////////////////////////////////////////
  // configuration image
  localparam int         CFG_ADDR_W = 6;
  localparam int         CFG_BYTES  = 64;
  localparam logic [9:0] CFG_BITS   = 10'(CFG_BYTES * 8);

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser lanes
  localparam int SY_W        = 8;
  localparam int SY_REQ      = 0;
  localparam int SY_STATUS   = 1;
  localparam int SY_DONE     = 2;
  localparam int SY_CHAIN    = 3;
  localparam int SY_USR_CLK  = 4;
  localparam int SY_USE_USR  = 5;
  localparam int SY_COMPLETE = 6;
  localparam int SY_ERROR    = 7;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_POR,
    ST_RESET,
    ST_WAIT_STATUS,
    ST_CONFIG,
    ST_INIT_WAIT,
    ST_STARTUP,
    ST_USER,
    ST_ERROR
  } psc_state_t;

  typedef struct packed {
    logic complete;
    logic error;
  } psc_link_stat_t;

  typedef struct packed {
    logic                  we;
    logic [CFG_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } psc_wr_t;

endpackage : psc_pkg

// File: psc_sync.sv
// two-flop level synchroniser into the reference clock domain
// assumes each lane is a slowly changing level
module psc_sync
  import psc_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [psc_pkg::SY_W-1:0] i_async,
  output logic      [psc_pkg::SY_W-1:0] o_sync
);
  import psc_pkg::*;

  logic [SY_W-1:0] meta_reg;
  logic [SY_W-1:0] sync_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : psc_sync

// File: psc_cfg_mem.sv
// configuration storage: written on the serial clock, read on the reference clock
// assumes reads only happen once the image is complete and writes have stopped
module psc_cfg_mem
  import psc_pkg::*;
(
  input  wire logic                           i_wr_clk,
  input  wire psc_pkg::psc_wr_t               i_wr,
  input  wire logic                           i_rd_clk,
  input  wire logic [psc_pkg::CFG_ADDR_W-1:0] i_rd_addr,
  output logic      [7:0]                     o_rd_data
);
  import psc_pkg::*;

  logic [7:0] mem [CFG_BYTES];
  logic [7:0] rd_reg;

  always_ff @(posedge i_wr_clk)
  begin
    if (i_wr.we)
      mem[i_wr.addr] <= i_wr.data;
  end

  always_ff @(posedge i_rd_clk)
  begin
    rd_reg <= mem[i_rd_addr];
  end

  assign o_rd_data = rd_reg;

endmodule : psc_cfg_mem

// File: psc_top.sv
// passive serial configuration slave: reset, configuration and start-up sequencing
// assumes external pull-ups on the shared status and done lines, host drives serial clock and data
module psc_top
  import psc_pkg::*;
(
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_cfg_clk,
  input  wire logic                           i_serial_load_bit,
  input  wire logic                           i_reconfig_req_n,
  input  wire logic                           i_status_line,
  output logic                                o_status_line,
  output logic                                o_status_line_oe,
  input  wire logic                           i_done_line,
  output logic                                o_done_line,
  output logic                                o_done_line_oe,
  input  wire logic                           i_chain_enable_in_n,
  output logic                                o_chain_enable_out_n,
  input  wire logic                           i_user_startup_clock,
  input  wire logic                           i_use_user_startup_clock,
  output logic                                o_user_mode,
  output logic                                o_user_io_oe,
  input  wire logic [psc_pkg::CFG_ADDR_W-1:0] i_rd_addr,
  output logic      [7:0]                     o_rd_data
);
  import psc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised inputs
  logic [SY_W-1:0] sy_in;
  logic [SY_W-1:0] sy;
  psc_link_stat_t  link_stat_reg;

  assign sy_in = {link_stat_reg.error, link_stat_reg.complete, i_use_user_startup_clock,
                  i_user_startup_clock, i_chain_enable_in_n, i_done_line, i_status_line,
                  i_reconfig_req_n};

  psc_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (sy_in),
    .o_sync    (sy)
  );

  wire req_s      = sy[SY_REQ];
  wire status_s   = sy[SY_STATUS];
  wire done_s     = sy[SY_DONE];
  wire chain_in_s = sy[SY_CHAIN];
  wire usr_clk_s  = sy[SY_USR_CLK];
  wire use_usr_s  = sy[SY_USE_USR];
  wire complete_s = sy[SY_COMPLETE];
  wire error_s    = sy[SY_ERROR];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  psc_state_t state_reg;
  psc_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       usr_prev_reg;
  logic       use_usr_reg;
  logic       status_oe_reg;
  logic       done_oe_reg;
  logic       chain_out_n_reg;
  logic       user_mode_reg;
  logic       link_run_reg;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction : sat_inc

  wire usr_rise    = usr_clk_s && !usr_prev_reg;
  wire por_done    = (cnt_reg >= POR_CYC - 8'h01);
  wire pulse_done  = (cnt_reg >= STATUS_MIN_CYC);
  wire start_done  = use_usr_reg ? (cnt_reg >= USER_STARTUP_EDGES)
                                 : (cnt_reg >= STARTUP_CYC);
  wire drv_status  = (state_next == ST_POR) || (state_next == ST_RESET) || (state_next == ST_ERROR);
  wire rel_done    = (state_next == ST_INIT_WAIT) || (state_next == ST_STARTUP) ||
                     (state_next == ST_USER);
  wire run_next    = (state_next == ST_CONFIG) && !chain_in_s;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = sat_inc(cnt_reg);
    case (state_reg)
      ST_POR:
        if (por_done)
        begin
          state_next = ST_RESET;
          cnt_next   = 8'h00;
        end
      ST_RESET:
        if (req_s && pulse_done)
          state_next = ST_WAIT_STATUS;
      ST_WAIT_STATUS:
        if (!req_s)
        begin
          state_next = ST_RESET;
          cnt_next   = 8'h00;
        end
        else if (status_s)
          state_next = ST_CONFIG;
      ST_CONFIG:
        if (!req_s)
        begin
          state_next = ST_RESET;
          cnt_next   = 8'h00;
        end
        else if (error_s || !status_s)
          state_next = ST_ERROR;
        else if (complete_s)
          state_next = ST_INIT_WAIT;
      ST_INIT_WAIT:
        if (!req_s)
        begin
          state_next = ST_RESET;
          cnt_next   = 8'h00;
        end
        else if (done_s)
        begin
          state_next = ST_STARTUP;
          cnt_next   = 8'h00;
        end
      ST_STARTUP:
      begin
        cnt_next = use_usr_reg ? (usr_rise ? sat_inc(cnt_reg) : cnt_reg) : sat_inc(cnt_reg);
        if (!req_s)
        begin
          state_next = ST_RESET;
          cnt_next   = 8'h00;
        end
        else if (start_done)
          state_next = ST_USER;
      end
      ST_USER, ST_ERROR:
        if (!req_s)
        begin
          state_next = ST_RESET;
          cnt_next   = 8'h00;
        end
      default:
      begin
        state_next = ST_POR;
        cnt_next   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg       <= ST_POR;
      cnt_reg         <= 8'h00;
      usr_prev_reg    <= 1'b0;
      use_usr_reg     <= 1'b0;
      status_oe_reg   <= 1'b1;
      done_oe_reg     <= 1'b1;
      chain_out_n_reg <= 1'b1;
      user_mode_reg   <= 1'b0;
      link_run_reg    <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      usr_prev_reg    <= usr_clk_s;
      use_usr_reg     <= (state_reg == ST_INIT_WAIT) ? use_usr_s : use_usr_reg;
      status_oe_reg   <= drv_status;
      done_oe_reg     <= !rel_done;
      chain_out_n_reg <= !rel_done;
      user_mode_reg   <= (state_next == ST_USER);
      link_run_reg    <= run_next;
    end
  end

  assign o_status_line        = 1'b0;
  assign o_done_line          = 1'b0;
  assign o_status_line_oe     = status_oe_reg;
  assign o_done_line_oe       = done_oe_reg;
  assign o_chain_enable_out_n = chain_out_n_reg;
  assign o_user_mode          = user_mode_reg;
  assign o_user_io_oe         = user_mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: held in reset by the sequencer whenever loading is not allowed
  logic [9:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  xsum_reg;
  psc_wr_t     wr_reg;

  wire [7:0] shift_next = {shift_reg[6:0], i_serial_load_bit};
  wire       byte_end   = (bit_cnt_reg[2:0] == 3'h7);
  wire       last_bit   = (bit_cnt_reg == CFG_BITS - 10'h001);
  wire       accept     = !link_stat_reg.complete && !link_stat_reg.error;

  always_ff @(posedge i_cfg_clk or negedge link_run_reg)
  begin
    if (!link_run_reg)
    begin
      bit_cnt_reg   <= 10'h000;
      shift_reg     <= 8'h00;
      xsum_reg      <= 8'h00;
      wr_reg        <= '0;
      link_stat_reg <= '0;
    end
    else
    begin
      wr_reg.we <= 1'b0;
      if (accept)
      begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 10'h001;
        if (byte_end)
        begin
          wr_reg.we   <= 1'b1;
          wr_reg.addr <= bit_cnt_reg[CFG_ADDR_W+2:3];
          wr_reg.data <= shift_next;
          xsum_reg    <= xsum_reg ^ shift_next;
        end
        if (last_bit)
        begin
          link_stat_reg.complete <= (xsum_reg ^ shift_next) == 8'h00;
          link_stat_reg.error    <= (xsum_reg ^ shift_next) != 8'h00;
        end
      end
    end
  end

  psc_cfg_mem u_mem (
    .i_wr_clk  (i_cfg_clk),
    .i_wr      (wr_reg),
    .i_rd_clk  (i_ref_clk),
    .i_rd_addr (i_rd_addr),
    .o_rd_data (o_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] low_cnt_reg;
  logic [7:0] edge_cnt_reg;
  logic [7:0] init_cyc_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      low_cnt_reg  <= 8'h00;
      edge_cnt_reg <= 8'h00;
      init_cyc_reg <= 8'h00;
    end
    else
    begin
      low_cnt_reg  <= o_status_line_oe ? sat_inc(low_cnt_reg) : 8'h00;
      edge_cnt_reg <= (state_reg != ST_STARTUP) ? 8'h00 : (usr_rise ? sat_inc(edge_cnt_reg) : edge_cnt_reg);
      init_cyc_reg <= (state_reg != ST_STARTUP) ? 8'h00 : sat_inc(init_cyc_reg);
    end
  end

  sequence s_req_fall;
    $fell(req_s) && (state_reg != ST_POR);
  endsequence

  sequence s_both_low;
    o_done_line_oe && o_status_line_oe;
  endsequence

  a_por_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == ST_POR) |-> o_status_line_oe && !o_user_io_oe)
    else $error("status or user io released during power-on reset");

  a_reset_stay: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == ST_RESET && !req_s) |=> (state_reg == ST_RESET))
    else $error("left reset while request line low");

  a_req_fall_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      s_req_fall |-> ##[1:2] s_both_low)
    else $error("done and status not driven low after request fall");

  a_status_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($fell(o_status_line_oe) && $past(state_reg) == ST_RESET)
      |-> $past(low_cnt_reg) >= STATUS_MIN_CYC)
    else $error("status low pulse shorter than minimum");

  a_status_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(req_s) && state_reg == ST_RESET) |-> ##[1:160] !o_status_line_oe)
    else $error("status not released in time after request rise");

  a_done_held: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == ST_CONFIG || state_reg == ST_WAIT_STATUS) |-> o_done_line_oe)
    else $error("done released before image complete");

  a_done_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == ST_CONFIG && complete_s && req_s && status_s && !error_s)
      |=> !o_done_line_oe && !o_chain_enable_out_n)
    else $error("done not released after complete image");

  a_user_edges: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(o_user_mode) && use_usr_reg) |-> edge_cnt_reg == USER_STARTUP_EDGES)
    else $error("user start-up clock edge count wrong");

  a_startup_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(o_user_mode) && !use_usr_reg)
      |-> init_cyc_reg >= STARTUP_LO_CYC && init_cyc_reg <= STARTUP_HI_CYC)
    else $error("start-up time out of window");

  a_error_halt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == ST_ERROR) |-> o_status_line_oe && !link_run_reg)
    else $error("error state does not halt configuration");

  a_chain_block: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      chain_in_s |=> !link_run_reg)
    else $error("loading while chain enable in is high");

  a_load_frozen: assert property (@(posedge i_cfg_clk) disable iff (!link_run_reg)
      link_stat_reg.complete |=> $stable(bit_cnt_reg))
    else $error("bits shifted after image complete");

endmodule : psc_top

// File: psc_host_model.sv
// host side of the serial link: request line, serial clock and data bit
// assumes the bench resolves the shared status and done wires and feeds them back
module psc_host_model
(
  input  wire logic i_status_wire,
  input  wire logic i_done_wire,
  output logic      o_cfg_clk,
  output logic      o_serial_load_bit,
  output logic      o_reconfig_req_n
);
  timeunit 1ns;
  timeprecision 100ps;

  realtime t_rise;

  initial
  begin
    o_cfg_clk         = 1'b0;
    o_serial_load_bit = 1'b0;
    o_reconfig_req_n  = 1'b1;
    t_rise            = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request pulse, low time never under 2 us
  task automatic request(input int low_ns);
    o_reconfig_req_n = 1'b0;
    #(low_ns > 2000 ? low_ns : 2000);
    o_reconfig_req_n = 1'b1;
    t_rise = $realtime;
  endtask : request

  // one bit per serial clock; clock stands low outside frames
  task automatic shift(input logic v);
    o_serial_load_bit = v;
    #7.5 o_cfg_clk = 1'b1;
    #7.5 o_cfg_clk = 1'b0;
  endtask : shift

  task automatic load(input logic [7:0] img[$], output logic ok);
    int i;
    int b;
    ok = 1'b0;
    for (i = 0; i < 400 && i_status_wire !== 1'b1; i++) #25;
    if (i_status_wire !== 1'b1) return;
    #1000;
    while ($realtime < t_rise + 5000) #25;
    #3.3;
    foreach (img[j])
      for (b = 7; b >= 0; b--) shift(img[j][b]);
    for (i = 0; i < 16 && i_done_wire !== 1'b1; i++) shift(~o_serial_load_bit);
    o_serial_load_bit = ~o_serial_load_bit;
    ok = 1'b1;
  endtask : load
endmodule : psc_host_model

// File: test_passive_serial_config_slave.sv
// self-checking bench for the passive serial configuration slave
// assumes pull-ups on the shared status and done wires, which the bench resolves
module test_passive_serial_config_slave;
  timeunit 1ns;
  timeprecision 100ps;
  import psc_pkg::*;

  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  user_clk = 1'b0;
  logic                  use_usr = 1'b0;
  logic                  chain_n = 1'b0;
  logic                  ext_status_low = 1'b0;
  logic                  ext_done_low = 1'b0;
  logic [CFG_ADDR_W-1:0] rd_addr = '0;
  logic [7:0]            rd_data;
  logic                  cfg_clk, sdata, req_n, st_oe, dn_oe, ceo_n, umode, io_oe, ok, st_lvl, dn_lvl;
  wire                   status_wire = !(st_oe || ext_status_low);
  wire                   done_wire = !(dn_oe || ext_done_low);
  logic [7:0]            img[$];
  logic [31:0]           rnd;
  int                    errors = 0;
  int                    num_checks = 0;
  int                    n;

  always #12.5 ref_clk = ~ref_clk;
  always #100 user_clk = ~user_clk;

  psc_host_model i_host (.i_status_wire(status_wire), .i_done_wire(done_wire), .o_cfg_clk(cfg_clk),
                         .o_serial_load_bit(sdata), .o_reconfig_req_n(req_n));

  psc_top i_dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cfg_clk(cfg_clk), .i_serial_load_bit(sdata),
                 .i_reconfig_req_n(req_n), .i_status_line(status_wire), .o_status_line(st_lvl),
                 .o_status_line_oe(st_oe), .i_done_line(done_wire), .o_done_line(dn_lvl), .o_done_line_oe(dn_oe),
                 .i_chain_enable_in_n(chain_n), .o_chain_enable_out_n(ceo_n), .i_user_startup_clock(user_clk),
                 .i_use_user_startup_clock(use_usr), .o_user_mode(umode), .o_user_io_oe(io_oe),
                 .i_rd_addr(rd_addr), .o_rd_data(rd_data));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic pick(input int k);
    case (k)
      0:       return st_oe;
      1:       return dn_oe;
      2:       return umode;
      default: return ceo_n;
    endcase
  endfunction : pick

  task automatic finish_test();
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic check_span(input int cnt, input int lo, input int hi);
    num_checks++;
    if (cnt < lo || cnt > hi)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, cnt, lo);
    end
  endtask : check_span

  task automatic wait_for(input int k, input logic v, input int lim, output int cnt);
    for (cnt = 0; cnt < lim && pick(k) !== v; cnt++) @(posedge ref_clk) #1;
    if (pick(k) !== v)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, pick(k), v);
      finish_test();
    end
  endtask : wait_for

  task automatic make_image(input logic bad);
    logic [7:0] x;
    x = 8'h00;
    img.delete();
    repeat (CFG_BYTES - 1)
    begin
      rnd = lfsr(rnd);
      img.push_back(rnd[7:0]);
      x ^= rnd[7:0];
    end
    img.push_back(x ^ {7'h00, bad});
  endtask : make_image

  task automatic load_image();
    i_host.load(img, ok);
    check({7'h00, ok}, 8'h01);
  endtask : load_image

  task automatic restart();
    int k;
    rnd = lfsr(rnd);
    @(posedge ref_clk) #1;
    fork
      i_host.request(2000 + 25 * int'(rnd[4:0]));
    join_none
    wait_for(0, 1'b1, 8, k);
    check({7'h00, dn_oe}, 8'h01);
    repeat (40) @(posedge ref_clk);
    #1 check({7'h00, st_oe}, 8'h01);
    check({7'h00, umode}, 8'h00);
    wait fork;
    wait_for(0, 1'b0, 8, k);
  endtask : restart

  task automatic readback();
    int i;
    for (i = 0; i < CFG_BYTES; i++)
    begin
      @(posedge ref_clk) #1 rd_addr = CFG_ADDR_W'(i);
      @(posedge ref_clk) #1 check(rd_data, img[i]);
    end
  endtask : readback

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial
  begin
    rnd = 32'hdef53b42;
    repeat (10) @(posedge ref_clk);
    #1 check({3'h0, st_oe, dn_oe, umode, io_oe, ceo_n}, 8'h19);
    check({6'h00, st_lvl, dn_lvl}, 8'h00);
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (150) @(posedge ref_clk);
    #1 check({7'h00, st_oe}, 8'h01);
    wait_for(0, 1'b0, 120, n);
    // good image while another device still holds the shared done low
    ext_done_low = 1'b1;
    make_image(1'b0);
    load_image();
    wait_for(1, 1'b0, 8, n);
    check({7'h00, ceo_n}, 8'h00);
    repeat (60) @(posedge ref_clk);
    #1 check({7'h00, umode}, 8'h00);
    ext_done_low = 1'b0;
    wait_for(2, 1'b1, 100, n);
    check_span(n, STARTUP_LO_CYC, STARTUP_HI_CYC);
    check({7'h00, io_oe}, 8'h01);
    readback();
    // corrupted checksum
    restart();
    make_image(1'b1);
    load_image();
    wait_for(0, 1'b1, 8, n);
    check({7'h00, dn_oe}, 8'h01);
    // status pulled low by another device in mid-frame
    restart();
    make_image(1'b0);
    fork
      load_image();
      begin
        repeat (300) @(posedge ref_clk);
        #1 ext_status_low = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 ext_status_low = 1'b0;
      end
    join
    check({6'h00, st_oe, dn_oe}, 8'h03);
    // chain enable in high blocks loading
    chain_n = 1'b1;
    restart();
    make_image(1'b0);
    load_image();
    check({6'h00, dn_oe, ceo_n}, 8'h03);
    chain_n = 1'b0;
    load_image();
    wait_for(1, 1'b0, 8, n);
    check({7'h00, ceo_n}, 8'h00);
    // start-up on the user clock
    use_usr = 1'b1;
    restart();
    make_image(1'b0);
    load_image();
    wait_for(2, 1'b1, 120, n);
    check_span(n, 72, 92);
    finish_test();
  end
endmodule : test_passive_serial_config_slave
